// ===== core/hbf_host.sv
// Host-side framer: sends one command frame, awaits ACK/NAK and any reply.
// Assumes a byte UART on sys_clk: tx with valid/ready, rx one-cycle strobes.
//
// How it works
// [RQ1] Frames open with start byte 02
// [RQ2] Descriptor: id, read flag, seven-bit length
// [RQ3] Id high byte; read flag tops byte two
// [RQ4] Data count equals descriptor length
// [RQ5] Check byte XORs descriptor and data
// [RQ6] Frames close with end byte 03
// [RQ7] Device answers 06 good, 15 bad
// [RQ8] Multi-byte values go low byte first
// [RQ9] Device checks order, XOR and count
// [RQ10] Device sends ACK only if checks pass
// [RQ11] Device drops frame after one-second gap
// [RQ12] Device idles again after 1.5 s silence
// [RQ13] Device runs commands from good frames
// [RQ14] Known read gets ACK plus reply
// [RQ15] Unknown read gets ACK, no reply
// [RQ16] Read frame has no data bytes
// [RQ17] No answer to read: no device
// [RQ18] No reply 500 ms after ACK: failed
// [RQ19] Device acknowledges every valid write
// [RQ20] Device never range-checks written data
// [RQ21] Confirm writes by reading back
// [RQ22] Device drops NAKed frame, goes idle
`timescale 1ns/100ps
`include "hbf_defines.svh"

module hbf_host #(
    parameter int ACK_WAIT_CYC = `HBF_ACK_WAIT_CYC,
    parameter int REPLY_WAIT_CYC = `HBF_REPLY_WAIT_CYC,
    parameter int TW = `HBF_TIMER_W
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic req_valid,
    input hbf_pkg::hbf_fd_t req_fd,
    output logic req_ready,
    input wire logic [7:0] wr_byte,
    output logic wr_next,
    output logic [7:0] tx_byte,
    output logic tx_valid,
    input wire logic tx_ready,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    output logic [7:0] rd_byte,
    output logic rd_valid,
    output logic done,
    output hbf_pkg::hbf_result_t result
);
    import hbf_pkg::*;

    localparam logic [TW-1:0] ACK_LIM = TW'(ACK_WAIT_CYC - 1);
    localparam logic [TW-1:0] REPLY_LIM = TW'(REPLY_WAIT_CYC - 1);

    hbf_state_t state, next_state;
    hbf_fd_t cur, next_cur;
    logic [`HBF_LEN_W-1:0] cnt, next_cnt;
    logic [7:0] chk, next_chk;
    logic [TW-1:0] timer, next_timer;
    logic listen, next_listen;
    logic [7:0] next_tx_byte;
    logic next_tx_valid, next_wr_next, next_done, next_req_ready;
    hbf_result_t next_result;
    logic fin, good;

    // ----------------------------------------------------------------
    // Reply receiver
    // ----------------------------------------------------------------
    hbf_reply_rx u_reply (
        .sys_clk(sys_clk),
        .rst(rst),
        .listen(listen),
        .exp_fd(cur),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .rd_byte(rd_byte),
        .rd_valid(rd_valid),
        .fin(fin),
        .good(good)
    );

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // One byte is loaded whenever the transmit holding flop is empty,
    // so the frame leaves one byte every second cycle at most and never trips the gap watchdog.
    always_comb begin
        next_state = state;
        next_cur = cur;
        next_cnt = cnt;
        next_chk = chk;
        next_timer = timer + 1'b1;
        next_listen = listen;
        next_tx_byte = tx_byte;
        next_tx_valid = tx_valid;
        next_wr_next = 1'b0;
        next_done = 1'b0;
        next_result = result;
        if (tx_valid && tx_ready) begin
            next_tx_valid = 1'b0;
        end
        unique case (state)
            S_IDLE: begin
                next_timer = '0;
                if (req_valid) begin
                    next_cur = req_fd;
                    next_tx_byte = `HBF_STX; // see RQ1
                    next_tx_valid = 1'b1;
                    next_state = S_D0;
                end
            end
            S_D0: if (!tx_valid) begin
                next_tx_byte = cur.cmd_id; // see RQ2 see RQ3
                next_tx_valid = 1'b1;
                next_chk = cur.cmd_id;
                next_state = S_D1;
            end
            S_D1: if (!tx_valid) begin
                next_tx_byte = {cur.rd, cur.len}; // see RQ2 see RQ3
                next_tx_valid = 1'b1;
                next_chk = chk ^ {cur.rd, cur.len};
                next_cnt = cur.len;
                // Read frames carry no data bytes; see RQ16
                next_state = (cur.rd || cur.len == '0) ? S_CHK : S_DATA;
            end
            S_DATA: if (!tx_valid) begin
                // User supplies values low byte first; see RQ8 see RQ4
                next_tx_byte = wr_byte;
                next_tx_valid = 1'b1;
                next_wr_next = 1'b1;
                next_chk = chk ^ wr_byte;
                next_cnt = cnt - 1'b1;
                if (cnt == 7'h01) begin
                    next_state = S_CHK;
                end
            end
            S_CHK: if (!tx_valid) begin
                next_tx_byte = chk; // see RQ5
                next_tx_valid = 1'b1;
                next_state = S_ETX;
            end
            S_ETX: if (!tx_valid) begin
                next_tx_byte = `HBF_ETX; // see RQ6
                next_tx_valid = 1'b1;
                next_state = S_ACK;
            end
            S_ACK: begin
                if (tx_valid) begin
                    next_timer = '0;
                end else if (rx_valid && rx_byte == `HBF_ACK) begin
                    // see RQ7 see RQ10 see RQ14 see RQ19
                    if (cur.rd) begin
                        next_listen = 1'b1;
                        next_timer = '0;
                        next_state = S_REPLY;
                    end else begin
                        next_done = 1'b1;
                        next_result = HBF_OK;
                        next_state = S_IDLE;
                    end
                end else if (rx_valid && rx_byte == `HBF_NAK) begin
                    // Device dropped the frame; see RQ7 see RQ22
                    next_done = 1'b1;
                    next_result = HBF_NAKED;
                    next_state = S_IDLE;
                end else if (timer == ACK_LIM) begin
                    next_done = 1'b1;
                    next_result = HBF_NO_DEVICE; // see RQ17
                    next_state = S_IDLE;
                end
            end
            S_REPLY: begin
                if (fin) begin
                    // Read-back data leaves unaltered for write checks; see RQ21
                    next_listen = 1'b0;
                    next_done = 1'b1;
                    next_result = good ? HBF_OK : HBF_REPLY_BAD;
                    next_state = S_IDLE;
                end else if (timer == REPLY_LIM) begin
                    // Also the outcome of an unknown read id; see RQ18 see RQ15
                    next_listen = 1'b0;
                    next_done = 1'b1;
                    next_result = HBF_REPLY_TIMEOUT;
                    next_state = S_IDLE;
                end
            end
        endcase
        next_req_ready = (next_state == S_IDLE);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= S_IDLE;
            cur <= '0;
            cnt <= '0;
            chk <= 8'h00;
            timer <= '0;
            listen <= 1'b0;
            tx_byte <= 8'h00;
            tx_valid <= 1'b0;
            wr_next <= 1'b0;
            done <= 1'b0;
            result <= HBF_OK;
            req_ready <= 1'b1;
        end else begin
            state <= next_state;
            cur <= next_cur;
            cnt <= next_cnt;
            chk <= next_chk;
            timer <= next_timer;
            listen <= next_listen;
            tx_byte <= next_tx_byte;
            tx_valid <= next_tx_valid;
            wr_next <= next_wr_next;
            done <= next_done;
            result <= next_result;
            req_ready <= next_req_ready;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    logic hs;
    logic [7:0] hs_xor;
    logic [7:0] hs_cnt;
    assign hs = tx_valid && tx_ready;
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            hs_xor <= 8'h00;
            hs_cnt <= 8'h00;
        end else if (hs && tx_byte == `HBF_STX && state == S_D0) begin
            hs_xor <= 8'h00;
            hs_cnt <= 8'h01;
        end else if (hs) begin
            hs_xor <= hs_xor ^ tx_byte;
            hs_cnt <= hs_cnt + 8'h01;
        end
    end

    sequence s_stx_sent;
        hs && state == S_D0;
    endsequence
    sequence s_cmd_loaded;
        ##[1:8] (tx_valid && tx_byte == cur.cmd_id && state == S_D1);
    endsequence

    a_start_byte: assert property (@(posedge sys_clk) disable iff (rst) // see RQ1
        state == S_IDLE && req_valid |=> tx_valid && tx_byte == `HBF_STX && !req_ready)
        else $error("frame did not open with start byte");
    a_id_follows: assert property (@(posedge sys_clk) disable iff (rst) // see RQ2
        s_stx_sent |-> s_cmd_loaded)
        else $error("command id did not follow start byte");
    a_check_byte: assert property (@(posedge sys_clk) disable iff (rst) // see RQ5
        hs && state == S_ETX |-> tx_byte == hs_xor)
        else $error("check byte is not XOR of descriptor and data");
    a_data_count: assert property (@(posedge sys_clk) disable iff (rst) // see RQ4
        hs && state == S_ETX |-> hs_cnt == (cur.rd ? 8'h03 : 8'h03 + {1'b0, cur.len}))
        else $error("wrong number of bytes before check byte");
    a_end_byte: assert property (@(posedge sys_clk) disable iff (rst) // see RQ6
        hs && state == S_ACK |-> tx_byte == `HBF_ETX)
        else $error("frame did not close with end byte");
    a_nak_closes: assert property (@(posedge sys_clk) disable iff (rst) // see RQ22
        state == S_ACK && !tx_valid && rx_valid && rx_byte == `HBF_NAK
        |=> done && result == HBF_NAKED && req_ready)
        else $error("negative answer not reported");
    a_no_device: assert property (@(posedge sys_clk) disable iff (rst) // see RQ17
        state == S_ACK && !tx_valid && !rx_valid && timer == ACK_LIM
        |=> done && result == HBF_NO_DEVICE)
        else $error("silent device not reported");
    a_reply_wait: assert property (@(posedge sys_clk) disable iff (rst) // see RQ18
        state == S_REPLY && !fin && timer == REPLY_LIM
        |=> done && result == HBF_REPLY_TIMEOUT && !listen)
        else $error("missing reply not reported");
    a_read_no_data: assert property (@(posedge sys_clk) disable iff (rst) // see RQ16
        state == S_D1 && !tx_valid && cur.rd |=> state == S_CHK && !wr_next)
        else $error("read frame carried data");

endmodule

// ===== core/hbf_defines.svh
// Constants of the host-side binary command framer.
// Assumes a 40 MHz system clock; counts derive from it.
`ifndef HBF_DEFINES_SVH
`define HBF_DEFINES_SVH

// ----------------------------------------------------------------
// Frame bytes
// ----------------------------------------------------------------
`define HBF_STX 8'h02
`define HBF_ETX 8'h03
`define HBF_ACK 8'h06
`define HBF_NAK 8'h15

// ----------------------------------------------------------------
// Field layout of the second descriptor byte
// ----------------------------------------------------------------
`define HBF_RD_BIT 7
`define HBF_LEN_W 7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HBF_CLK_HZ 40000000
`define HBF_ACK_WAIT_MS 1000
`define HBF_REPLY_WAIT_MS 500
`define HBF_ACK_WAIT_CYC (`HBF_CLK_HZ / 1000 * `HBF_ACK_WAIT_MS)
`define HBF_REPLY_WAIT_CYC (`HBF_CLK_HZ / 1000 * `HBF_REPLY_WAIT_MS)
`define HBF_TIMER_W 26

`endif

// ===== core/hbf_pkg.sv
// Types shared by the host framer and its reply receiver.
// Assumes hbf_defines.svh sits on the include path.
`include "hbf_defines.svh"

package hbf_pkg;

    // Command id in the top byte, read flag then length below it
    typedef struct packed {
        logic [7:0] cmd_id;
        logic rd;
        logic [`HBF_LEN_W-1:0] len;
    } hbf_fd_t;

    typedef enum logic [2:0] {
        HBF_OK,
        HBF_NAKED,
        HBF_NO_DEVICE,
        HBF_REPLY_TIMEOUT,
        HBF_REPLY_BAD
    } hbf_result_t;

    typedef enum logic [3:0] {
        S_IDLE, S_D0, S_D1, S_DATA, S_CHK, S_ETX, S_ACK, S_REPLY
    } hbf_state_t;

    typedef enum logic [2:0] {
        R_STX, R_D0, R_D1, R_DATA, R_CHK, R_ETX, R_END
    } hbf_rstate_t;

endpackage

// ===== core/hbf_reply_rx.sv
// Reply frame receiver of the host framer.
// Assumes received bytes arrive as one-cycle strobes on sys_clk.
`timescale 1ns/100ps
`include "hbf_defines.svh"

module hbf_reply_rx (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic listen,
    input hbf_pkg::hbf_fd_t exp_fd,
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    output logic [7:0] rd_byte,
    output logic rd_valid,
    output logic fin,
    output logic good
);
    import hbf_pkg::*;

    hbf_rstate_t state, next_state;
    logic [7:0] chk, next_chk;
    logic [`HBF_LEN_W-1:0] cnt, next_cnt;
    logic bad, next_bad;
    logic [7:0] next_rd_byte;
    logic next_rd_valid, next_fin, next_good;

    // ----------------------------------------------------------------
    // Frame walk
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_chk = chk;
        next_cnt = cnt;
        next_bad = bad;
        next_rd_byte = rd_byte;
        next_rd_valid = 1'b0;
        next_fin = 1'b0;
        next_good = good;
        if (!listen) begin
            next_state = R_STX;
            next_bad = 1'b0;
        end else if (rx_valid) begin
            unique case (state)
                R_STX: begin
                    // Noise before the start byte is skipped; see RQ1
                    if (rx_byte == `HBF_STX) begin
                        next_state = R_D0;
                    end
                end
                R_D0: begin
                    next_bad = bad | (rx_byte != exp_fd.cmd_id);
                    next_chk = rx_byte;
                    next_state = R_D1;
                end
                R_D1: begin
                    // Reply carries write flag and the asked length; see RQ2 see RQ3
                    next_bad = bad | (rx_byte != {1'b0, exp_fd.len});
                    next_chk = chk ^ rx_byte;
                    next_cnt = rx_byte[`HBF_LEN_W-1:0];
                    next_state = (rx_byte[`HBF_LEN_W-1:0] == '0) ? R_CHK : R_DATA;
                end
                R_DATA: begin
                    // Bytes leave in arrival order, least significant first; see RQ8 see RQ4
                    next_rd_byte = rx_byte;
                    next_rd_valid = 1'b1;
                    next_chk = chk ^ rx_byte;
                    next_cnt = cnt - 1'b1;
                    if (cnt == 7'h01) begin
                        next_state = R_CHK;
                    end
                end
                R_CHK: begin
                    next_bad = bad | (rx_byte != chk); // see RQ5
                    next_state = R_ETX;
                end
                R_ETX: begin
                    next_fin = 1'b1;
                    next_good = !bad && (rx_byte == `HBF_ETX); // see RQ6
                    next_state = R_END;
                end
                R_END: begin
                    next_state = R_END;
                end
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state <= R_STX;
            chk <= 8'h00;
            cnt <= '0;
            bad <= 1'b0;
            rd_byte <= 8'h00;
            rd_valid <= 1'b0;
            fin <= 1'b0;
            good <= 1'b0;
        end else begin
            state <= next_state;
            chk <= next_chk;
            cnt <= next_cnt;
            bad <= next_bad;
            rd_byte <= next_rd_byte;
            rd_valid <= next_rd_valid;
            fin <= next_fin;
            good <= next_good;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    a_reply_good_end: assert property (@(posedge sys_clk) disable iff (rst) // see RQ6
        fin && good |-> $past(rx_byte) == `HBF_ETX && $past(rx_valid))
        else $error("reply accepted without end byte");
    a_reply_data_only: assert property (@(posedge sys_clk) disable iff (rst) // see RQ4
        rd_valid |-> $past(state) == R_DATA)
        else $error("reply byte outside data field");

endmodule

// ===== bench/hbf_dev_model.sv
// Behavioural device at the far end of the serial link for the host framer bench.
// Assumes byte handshakes on sys_clk: tx taken on tx_valid && tx_ready, rx one-cycle strobes.
`timescale 1ns/100ps

module hbf_dev_model #(
    parameter int LATE = 400,
    parameter logic [7:0] UNKNOWN_ID = 8'hff,
    parameter int GAP = 100
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [7:0] tx_byte,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_byte,
    output logic rx_valid,
    input wire logic [2:0] mode,
    input wire logic stall
);
    // Modes: 0 normal, 1 mute, 2 refuse, 3 late reply, 4 corrupt reply check byte
    logic [7:0] q[$];
    logic [7:0] mem [256][4];
    logic [7:0] buff [4];
    logic [7:0] id;
    logic [7:0] d1;
    logic [7:0] b;
    logic [7:0] x;
    logic ok;
    logic busy = 1'b0;
    logic lost = 1'b0;

    // ----------------------------------------------------------------
    // Receive side
    // ----------------------------------------------------------------
    // Stall toggles ready each cycle, so the host may hold any frame byte, for one cycle at most
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            tx_ready <= 1'b0;
        end else begin
            tx_ready <= stall ? ~tx_ready : 1'b1;
        end
    end

    always @(posedge sys_clk) begin
        if (!rst && tx_valid && tx_ready) begin
            q.push_back(tx_byte);
        end
    end

    task automatic get(output logic [7:0] v);
        int w;
        w = 0;
        while (q.size() == 0) begin
            @(posedge sys_clk);
            w++;
        end
        lost |= busy && w > GAP;
        v = q.pop_front();
    endtask

    // Idle line shows the inverse of the last byte, never a stale copy
    task automatic send(input logic [7:0] v);
        @(posedge sys_clk);
        rx_byte <= v;
        rx_valid <= 1'b1;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
        rx_byte <= ~v;
        repeat (2) @(posedge sys_clk);
    endtask

    // ----------------------------------------------------------------
    // Frame handling
    // ----------------------------------------------------------------
    initial begin
        rx_valid = 1'b0;
        rx_byte = 8'h00;
        forever begin
            get(b);
            if (b == 8'h02) begin
                busy = 1'b1;
                lost = 1'b0;
                get(id);
                get(d1);
                x = id ^ d1;
                if (!d1[7]) begin
                    for (int i = 0; i < d1[6:0]; i++) begin
                        get(b);
                        x ^= b;
                        if (i < 4) begin
                            buff[i] = b;
                        end
                    end
                end
                get(b);
                ok = (b == x) && (mode != 3'd2);
                get(b);
                ok = ok && (b == 8'h03);
                busy = 1'b0;
                repeat (lost ? GAP * 3 / 2 : 0) @(posedge sys_clk);
                q.delete();
                if (mode != 3'd1 && !lost) begin
                    send(ok ? 8'h06 : 8'h15);
                    // Refused or unknown frames change nothing
                    if (ok && id != UNKNOWN_ID) begin
                        if (!d1[7]) begin
                            for (int i = 0; i < d1[6:0] && i < 4; i++) begin
                                mem[id][i] = buff[i];
                            end
                        end else begin
                            if (mode == 3'd3) begin
                                repeat (LATE) @(posedge sys_clk);
                            end
                            x = id ^ {1'b0, d1[6:0]};
                            send(8'h02);
                            send(id);
                            send({1'b0, d1[6:0]});
                            for (int i = 0; i < d1[6:0]; i++) begin
                                send(mem[id][i]);
                                x ^= mem[id][i];
                            end
                            send(mode == 3'd4 ? ~x : x);
                            send(8'h03);
                        end
                    end
                end
            end
        end
    end
endmodule

// ===== bench/test_hbf_host.sv
// Self-checking bench for the host framer against the behavioural device model.
// Assumes hbf_pkg and hbf_dev_model compile before this file.
`timescale 1ns/100ps

module test_hbf_host;
    import hbf_pkg::*;

    localparam int ACK_W = 200;
    localparam int REPLY_W = 300;
    localparam int LATE = 400;

    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    hbf_fd_t req_fd = '0;
    logic req_ready, wr_next, tx_valid, tx_ready, rx_valid, rd_valid, done;
    logic [7:0] wr_byte, tx_byte, rx_byte, rd_byte;
    hbf_result_t result;
    logic [2:0] mode = 3'd0;
    logic stall = 1'b0;
    logic [7:0] wbuf [128];
    logic [6:0] wr_idx = '0;
    logic [7:0] txq[$];
    logic [7:0] rdq[$];
    logic [7:0] exp_rd[$];
    int cyc = 0;
    int last_tx = 0;
    int ack_at = 0;
    int err_count = 0;
    int samples_checked = 0;

    // ----------------------------------------------------------------
    // Clock, design and device
    // ----------------------------------------------------------------
    always #12.5 sys_clk = ~sys_clk;

    assign wr_byte = wbuf[wr_idx];

    hbf_host #(.ACK_WAIT_CYC(ACK_W), .REPLY_WAIT_CYC(REPLY_W), .TW(26)) dut (
        .sys_clk(sys_clk), .rst(rst), .req_valid(req_valid), .req_fd(req_fd),
        .req_ready(req_ready), .wr_byte(wr_byte), .wr_next(wr_next), .tx_byte(tx_byte),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .rd_byte(rd_byte), .rd_valid(rd_valid), .done(done), .result(result));

    hbf_dev_model #(.LATE(LATE), .UNKNOWN_ID(8'hff)) dev (
        .sys_clk(sys_clk), .rst(rst), .tx_byte(tx_byte), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid), .mode(mode), .stall(stall));

    // Wire monitor, independent of the design's own view
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (req_valid) begin
            wr_idx <= '0;
        end else if (wr_next === 1'b1) begin
            wr_idx <= wr_idx + 7'd1;
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            txq.push_back(tx_byte);
            last_tx <= cyc;
        end
        if (rd_valid === 1'b1) begin
            rdq.push_back(rd_byte);
        end
        if (rx_valid === 1'b1 && rx_byte == 8'h06) begin
            ack_at <= cyc;
        end
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic test_done;
        $display("Checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // One whole transaction, judged on the wire and at the user side
    task automatic xact(input logic [7:0] id, input logic rd, input logic [6:0] len,
                        input logic [2:0] md, input hbf_result_t exp_res);
        logic [7:0] fr[$];
        logic [7:0] x;
        int t;
        int d;
        mode <= md;
        txq.delete();
        rdq.delete();
        @(posedge sys_clk);
        req_valid <= 1'b1;
        req_fd <= {id, rd, len};
        @(posedge sys_clk);
        req_valid <= 1'b0;
        t = 0;
        do begin
            @(posedge sys_clk);
            #1;
            t++;
        end while (done !== 1'b1 && t < 3000);
        d = cyc;
        chk("done seen", 1, done);
        chk("result", exp_res, result);
        chk("ready at done", 1, req_ready);
        x = id ^ {rd, len};
        fr = '{8'h02, id, {rd, len}};
        if (!rd) begin
            for (int i = 0; i < len; i++) begin
                fr.push_back(wbuf[i]);
                x ^= wbuf[i];
            end
        end
        fr.push_back(x);
        fr.push_back(8'h03);
        @(posedge sys_clk);
        #1;
        chk("done pulse", 0, done);
        chk("frame length", fr.size(), txq.size());
        foreach (fr[i]) chk("frame byte", fr[i], txq[i]);
        chk("reply length", exp_rd.size(), rdq.size());
        foreach (exp_rd[i]) chk("reply byte", exp_rd[i], rdq[i]);
        if (exp_res == HBF_NO_DEVICE) begin
            chk("ack wait", 1, (d - last_tx >= ACK_W - 2) && (d - last_tx <= ACK_W + 6));
        end
        if (exp_res == HBF_REPLY_TIMEOUT) begin
            chk("reply wait", 1, (d - ack_at >= REPLY_W - 2) && (d - ack_at <= REPLY_W + 6));
        end
        repeat (20) @(posedge sys_clk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic s_write_stall;
        stall <= 1'b1;
        wbuf[0] = 8'h5a;
        wbuf[1] = 8'ha5;
        exp_rd.delete();
        xact(8'h46, 1'b0, 7'd2, 3'd0, HBF_OK);
        stall <= 1'b0;
    endtask

    task automatic s_read_back;
        exp_rd = '{8'h5a, 8'ha5};
        xact(8'h46, 1'b1, 7'd2, 3'd0, HBF_OK);
    endtask

    task automatic s_unknown_ids;
        wbuf[0] = 8'h77;
        exp_rd.delete();
        xact(8'hff, 1'b0, 7'd1, 3'd0, HBF_OK);
        xact(8'hff, 1'b1, 7'd1, 3'd0, HBF_REPLY_TIMEOUT);
    endtask

    // Empty and longest data fields
    task automatic s_len_bounds;
        exp_rd.delete();
        xact(8'h10, 1'b0, 7'd0, 3'd0, HBF_OK);
        for (int i = 0; i < 128; i++) begin
            wbuf[i] = 8'(i * 3 + 1);
        end
        xact(8'h20, 1'b0, 7'd127, 3'd0, HBF_OK);
    endtask

    // Refused write must not land; device then serves the next frame
    task automatic s_refused;
        wbuf[0] = 8'h11;
        wbuf[1] = 8'h22;
        exp_rd.delete();
        xact(8'h46, 1'b0, 7'd2, 3'd2, HBF_NAKED);
        exp_rd = '{8'h5a, 8'ha5};
        xact(8'h46, 1'b1, 7'd2, 3'd0, HBF_OK);
    endtask

    task automatic s_faults;
        exp_rd.delete();
        xact(8'h43, 1'b1, 7'd2, 3'd1, HBF_NO_DEVICE);
        xact(8'h46, 1'b1, 7'd2, 3'd3, HBF_REPLY_TIMEOUT);
        repeat (LATE + 100) @(posedge sys_clk);
        exp_rd = '{8'h5a, 8'ha5};
        xact(8'h46, 1'b1, 7'd2, 3'd4, HBF_REPLY_BAD);
    endtask

    // ----------------------------------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------------------------------
    initial begin
        for (int i = 0; i < 128; i++) begin
            wbuf[i] = 8'h00;
        end
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        #1;
        chk("reset ready", 1, req_ready);
        chk("reset tx_valid", 0, tx_valid);
        chk("reset done", 0, done);
        s_write_stall();
        s_read_back();
        s_unknown_ids();
        s_len_bounds();
        s_refused();
        s_faults();
        test_done();
    end

    // Roughly ten transactions of under a thousand cycles each
    initial begin
        repeat (60000) @(posedge sys_clk);
        err_count++;
        $display("MISMATCH watchdog expected finish seen hang");
        test_done();
    end
endmodule
